//--- hdl/wic_pkg.sv
// Constants for the wake-up and interrupt controller.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
`default_nettype none
package wic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  WIC_IDX_STACK     = 8'h02;
	localparam logic [7:0]  WIC_IDX_ENABLE    = 8'h04;
	localparam logic [7:0]  WIC_IDX_REQUEST   = 8'h05;
	localparam logic [7:0]  WIC_IDX_WAKE_CTRL = 8'h08;
	localparam logic [7:0]  WIC_IDX_EDGE      = 8'h0c;
	localparam logic [7:0]  WIC_IDX_PIN_CFG   = 8'h20;
	localparam logic [7:0]  WIC_IDX_TIMER_CFG = 8'h21;
	localparam logic [7:0]  WIC_IDX_STATUS    = 8'h22;
	// Interrupt line bit positions, shared by enable and request
	localparam int          WIC_BIT_PA        = 0;
	localparam int          WIC_BIT_PB        = 1;
	localparam int          WIC_BIT_T16       = 2;
	localparam int          WIC_BIT_CMP       = 4;
	localparam int          WIC_BIT_T2        = 6;
	localparam int          WIC_BIT_T3        = 7;
	localparam logic [7:0]  WIC_IRQ_MASK      = 8'hd7;
	// Wake control, edge select and configuration fields
	localparam int          WIC_BIT_FAST_WAKE = 5;
	localparam int          WIC_EDGE_PA_LSB   = 0;
	localparam int          WIC_EDGE_PB_LSB   = 2;
	localparam int          WIC_BIT_EDGE_T16  = 4;
	localparam int          WIC_DIR_LSB       = 0;
	localparam int          WIC_DIE_LSB       = 3;
	localparam int          WIC_BIT_CMP_WAKE  = 6;
	localparam int          WIC_BIT_CMP_EN    = 7;
	localparam int          WIC_TSYS_LSB      = 0;
	localparam int          WIC_TOSC_LSB      = 3;
	localparam int          WIC_BIT_LRC_EN    = 6;
	// Edge select codes
	localparam logic [1:0]  WIC_EDGE_BOTH     = 2'h0;
	localparam logic [1:0]  WIC_EDGE_RISE     = 2'h1;
	localparam logic [1:0]  WIC_EDGE_FALL     = 2'h2;
	// Reset values
	localparam logic [7:0]  WIC_RST_ZERO      = 8'h00;
	localparam logic [7:0]  WIC_RST_TIMER_CFG = 8'h40;
	// Interrupt entry and stack
	localparam logic [15:0] WIC_VECTOR        = 16'h0010;
	localparam logic [7:0]  WIC_STACK_STEP    = 8'h02;
	// Wake-up latency in low-speed RC periods
	localparam logic [11:0] WIC_WAKE_NORMAL   = 12'hbb8;
	localparam logic [11:0] WIC_WAKE_FAST     = 12'h02d;
	typedef enum logic [1:0] {
		WIC_PWR_ON   = 2'b00,
		WIC_PWR_SAVE = 2'b01,
		WIC_PWR_DOWN = 2'b10,
		WIC_PWR_WAKE = 2'b11
	} wic_power_type;
endpackage : wic_pkg
`default_nettype wire

//--- hdl/wic_controller.sv
// Wake-up, sleep-state and interrupt controller of a small 8-bit core.
// Assumes AHB-Lite single word transfers, pins and RC clock asynchronous, CPU and timer strobes on ref_clk.
`default_nettype none
module wic_controller
	import wic_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sleep_save_cmd,
	input  wire logic        sleep_down_cmd,
	input  wire logic        gint_enable_cmd,
	input  wire logic        gint_disable_cmd,
	input  wire logic        irq_taken,
	input  wire logic        reti_cmd,
	input  wire logic        port_a_pin_zero,
	input  wire logic        port_a_pin_five,
	input  wire logic        port_b_pin_zero,
	input  wire logic        low_speed_rc_osc,
	input  wire logic [2:0]  timer_match,
	input  wire logic [2:0]  timer_event,
	input  wire logic        comparator_out,
	output logic             cpu_irq,
	output logic             system_clock_run,
	output logic             oscillators_run,
	output logic             program_memory_on,
	output logic             resume_low_speed,
	output logic             wake_resume,
	output logic      [2:0]  timer_run,
	output logic             stack_write,
	output logic             stack_read,
	output logic      [7:0]  stack_addr,
	output logic      [15:0] vector_addr
);
	wic_power_type pwr_reg;
	logic [3:0]  sync1_reg;
	logic [3:0]  sync2_reg;
	logic [3:0]  sync3_reg;
	logic [2:0]  tev_prev_reg;
	logic        cmp_prev_reg;
	logic [7:0]  enable_reg;
	logic [7:0]  request_reg;
	logic [7:0]  request_next;
	logic [7:0]  edge_reg;
	logic [7:0]  wake_ctrl_reg;
	logic [7:0]  pin_cfg_reg;
	logic [7:0]  timer_cfg_reg;
	logic [7:0]  stack_pointer_reg;
	logic        gate_reg;
	logic [11:0] wake_cnt_reg;
	logic        ap_valid_reg;
	logic        ap_write_reg;
	logic [7:0]  ap_index_reg;
	logic        rd_wait_reg;
	logic [31:0] hrdata_reg;
	logic [7:0]  event_set;
	logic [2:0]  pin_change;
	logic        lrc_tick;
	logic        pin_wake;
	logic        timer_wake;
	logic        cmp_wake;
	logic        wr_en;
	logic [7:0]  rd_value;

	// Edge match against a two-bit select; the reserved code never fires
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		unique case (sel)
			WIC_EDGE_BOTH: edge_hit = prev ^ cur;
			WIC_EDGE_RISE: edge_hit = ~prev & cur;
			WIC_EDGE_FALL: edge_hit = prev & ~cur;
			default:       edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// Pin and RC synchronisers with a third stage for edges; timer and comparator history needs none
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_reg    <= 4'h0;
			sync2_reg    <= 4'h0;
			sync3_reg    <= 4'h0;
			tev_prev_reg <= 3'h0;
			cmp_prev_reg <= 1'b0;
		end else begin
			sync1_reg    <= {low_speed_rc_osc, port_b_pin_zero, port_a_pin_five, port_a_pin_zero};
			sync2_reg    <= sync1_reg;
			sync3_reg    <= sync2_reg;
			tev_prev_reg <= timer_event;
			cmp_prev_reg <= comparator_out;
		end
	end

	assign lrc_tick   = sync2_reg[3] & ~sync3_reg[3];
	assign pin_change = sync2_reg[2:0] ^ sync3_reg[2:0];
	// Wake sources
	assign pin_wake   = |(pin_change & ~pin_cfg_reg[WIC_DIR_LSB +: 3] & pin_cfg_reg[WIC_DIE_LSB +: 3]);
	assign timer_wake = (pwr_reg == WIC_PWR_SAVE)
		& |(timer_match & ~timer_cfg_reg[WIC_TSYS_LSB +: 3]);
	assign cmp_wake   = (pwr_reg == WIC_PWR_SAVE) & pin_cfg_reg[WIC_BIT_CMP_EN]
		& pin_cfg_reg[WIC_BIT_CMP_WAKE] & ~cmp_prev_reg & comparator_out;

	// Power state machine; pin wake waits out the oscillator start-up delay
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pwr_reg      <= WIC_PWR_ON;
			wake_cnt_reg <= 12'h000;
			wake_resume  <= 1'b0;
		end else begin
			wake_resume <= 1'b0;
			unique case (pwr_reg)
				WIC_PWR_ON: begin
					if (sleep_down_cmd) begin
						pwr_reg <= WIC_PWR_DOWN;
					end else if (sleep_save_cmd) begin
						pwr_reg <= WIC_PWR_SAVE;
					end
				end
				WIC_PWR_SAVE: begin
					if (pin_wake) begin
						pwr_reg      <= WIC_PWR_WAKE;
						wake_cnt_reg <= 12'h000;
					end else if (timer_wake | cmp_wake) begin
						pwr_reg     <= WIC_PWR_ON;
						wake_resume <= 1'b1;
					end
				end
				WIC_PWR_DOWN: begin
					if (pin_wake) begin
						pwr_reg      <= WIC_PWR_WAKE;
						wake_cnt_reg <= 12'h000;
					end
				end
				WIC_PWR_WAKE: begin
					if (lrc_tick) begin
						if (wake_cnt_reg == (wake_ctrl_reg[WIC_BIT_FAST_WAKE] ? WIC_WAKE_FAST : WIC_WAKE_NORMAL)
								- 12'h001) begin
							pwr_reg     <= WIC_PWR_ON;
							wake_resume <= 1'b1;
						end
						wake_cnt_reg <= wake_cnt_reg + 12'h001;
					end
				end
			endcase
		end
	end

	// Resume from power-save selects the RC clock until software rewrites wake control
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			resume_low_speed <= 1'b0;
		end else if (pwr_reg == WIC_PWR_SAVE && (pin_wake | timer_wake | cmp_wake)) begin
			resume_low_speed <= 1'b1;
		end else if (wr_en && ap_index_reg == WIC_IDX_WAKE_CTRL) begin
			resume_low_speed <= 1'b0;
		end
	end

	// Clock and memory gating; wake state keeps the CPU parked while the RC counts
	assign system_clock_run  = (pwr_reg == WIC_PWR_ON);
	assign oscillators_run   = (pwr_reg != WIC_PWR_DOWN);
	assign program_memory_on = (pwr_reg == WIC_PWR_ON);
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			timer_run[i] = (pwr_reg == WIC_PWR_ON)
				| ((pwr_reg == WIC_PWR_SAVE) & ~timer_cfg_reg[WIC_TSYS_LSB + i]
				& timer_cfg_reg[WIC_TOSC_LSB + i]);
		end
	end

	// Seven event sources into six flags; both port-A pins share one edge select, T2, T3 and comparator fire on rising edges
	always_comb begin
		event_set = 8'h00;
		event_set[WIC_BIT_PA] = (pin_cfg_reg[WIC_DIE_LSB]
			& edge_hit(edge_reg[WIC_EDGE_PA_LSB +: 2], sync3_reg[0], sync2_reg[0]))
			| (pin_cfg_reg[WIC_DIE_LSB + 1]
			& edge_hit(edge_reg[WIC_EDGE_PA_LSB +: 2], sync3_reg[1], sync2_reg[1]));
		event_set[WIC_BIT_PB] = pin_cfg_reg[WIC_DIE_LSB + 2]
			& edge_hit(edge_reg[WIC_EDGE_PB_LSB +: 2], sync3_reg[2], sync2_reg[2]);
		event_set[WIC_BIT_T16] = edge_hit(edge_reg[WIC_BIT_EDGE_T16] ? WIC_EDGE_FALL : WIC_EDGE_RISE,
			tev_prev_reg[0], timer_event[0]);
		event_set[WIC_BIT_T2]  = ~tev_prev_reg[1] & timer_event[1];
		event_set[WIC_BIT_T3]  = ~tev_prev_reg[2] & timer_event[2];
		event_set[WIC_BIT_CMP] = ~cmp_prev_reg & comparator_out;
	end

	// AHB-Lite address phase capture; only taken while the bus is ready
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_index_reg <= 8'h00;
		end else if (hready) begin
			ap_valid_reg <= hsel & htrans[1];
			ap_write_reg <= hwrite;
			ap_index_reg <= haddr[9:2];
		end
	end

	// Writes are ignored while asleep so nothing shifts in power-down
	assign wr_en = ap_valid_reg & ap_write_reg & (pwr_reg == WIC_PWR_ON);
	// Readback mux; unmapped words read zero
	always_comb begin
		unique case (ap_index_reg)
			WIC_IDX_STACK:     rd_value = stack_pointer_reg;
			WIC_IDX_ENABLE:    rd_value = enable_reg;
			WIC_IDX_REQUEST:   rd_value = request_reg;
			WIC_IDX_WAKE_CTRL: rd_value = wake_ctrl_reg;
			WIC_IDX_EDGE:      rd_value = edge_reg;
			WIC_IDX_PIN_CFG:   rd_value = pin_cfg_reg;
			WIC_IDX_TIMER_CFG: rd_value = timer_cfg_reg;
			WIC_IDX_STATUS:    rd_value = {4'h0, resume_low_speed, gate_reg, pwr_reg};
			default:           rd_value = 8'h00;
		endcase
	end

	// One wait state on reads so hrdata comes from a flop and sees the last write
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_wait_reg <= 1'b0;
			hrdata_reg  <= 32'h0000_0000;
		end else begin
			rd_wait_reg <= ap_valid_reg & ~ap_write_reg & ~rd_wait_reg;
			if (ap_valid_reg & ~ap_write_reg & ~rd_wait_reg) begin
				hrdata_reg <= {24'h00_0000, rd_value};
			end
		end
	end
	assign hreadyout = ~(ap_valid_reg & ~ap_write_reg & ~rd_wait_reg);
	assign hrdata    = hrdata_reg;
	assign hresp     = 1'b0;
	// Plain software registers; reserved enable bits stay zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			enable_reg    <= WIC_RST_ZERO;
			edge_reg      <= WIC_RST_ZERO;
			wake_ctrl_reg <= WIC_RST_ZERO;
			pin_cfg_reg   <= WIC_RST_ZERO;
			timer_cfg_reg <= WIC_RST_TIMER_CFG;
		end else if (wr_en) begin
			unique case (ap_index_reg)
				WIC_IDX_ENABLE:    enable_reg    <= hwdata[7:0] & WIC_IRQ_MASK;
				WIC_IDX_EDGE:      edge_reg      <= {3'h0, hwdata[4:0]};
				WIC_IDX_WAKE_CTRL: wake_ctrl_reg <= hwdata[7:0];
				WIC_IDX_PIN_CFG:   pin_cfg_reg   <= hwdata[7:0];
				WIC_IDX_TIMER_CFG: timer_cfg_reg <= {1'b0, hwdata[6:0]};
				default: ;
			endcase
		end
	end

	// Request flags: a write keeps only the ones written, a new event always wins
	always_comb begin
		request_next = request_reg;
		if (wr_en && ap_index_reg == WIC_IDX_REQUEST) begin
			request_next = request_reg & hwdata[7:0];
		end
		request_next = (request_next | event_set) & WIC_IRQ_MASK;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			request_reg <= WIC_RST_ZERO;
		end else begin
			request_reg <= request_next;
		end
	end
	// Global gate, stack pointer and stack strobes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			gate_reg          <= 1'b0;
			stack_pointer_reg <= WIC_RST_ZERO;
			stack_write       <= 1'b0;
			stack_read        <= 1'b0;
			stack_addr        <= 8'h00;
		end else begin
			stack_write <= 1'b0;
			stack_read  <= 1'b0;
			if (irq_taken) begin
				stack_write       <= 1'b1;
				stack_addr        <= stack_pointer_reg;
				stack_pointer_reg <= stack_pointer_reg + WIC_STACK_STEP;
				gate_reg          <= 1'b0;
			end else if (reti_cmd) begin
				stack_read        <= 1'b1;
				stack_addr        <= stack_pointer_reg - WIC_STACK_STEP;
				stack_pointer_reg <= stack_pointer_reg - WIC_STACK_STEP;
				gate_reg          <= 1'b1;
			end else begin
				if (gint_enable_cmd) begin
					gate_reg <= 1'b1;
				end else if (gint_disable_cmd) begin
					gate_reg <= 1'b0;
				end
				if (wr_en && ap_index_reg == WIC_IDX_STACK) begin
					stack_pointer_reg <= hwdata[7:0];
				end
			end
		end
	end
	// Registered request to the CPU; gate must be open
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cpu_irq     <= 1'b0;
			vector_addr <= 16'h0000;
		end else begin
			cpu_irq     <= gate_reg & |(enable_reg & request_reg);
			vector_addr <= WIC_VECTOR;
		end
	end
	// Checks
	sequence s_entry;
		irq_taken ##1 stack_write;
	endsequence
	property p_irq_gated;
		@(posedge ref_clk) disable iff (!rst_n)
		cpu_irq |-> $past(gate_reg) && |($past(enable_reg) & $past(request_reg));
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq raised without gate or enable");
	property p_entry_closes;
		@(posedge ref_clk) disable iff (!rst_n)
		s_entry |-> !gate_reg && stack_pointer_reg == stack_addr + WIC_STACK_STEP;
	endproperty
	a_entry_closes: assert property (p_entry_closes) else $error("entry did not push or close gate");
	property p_reti_opens;
		@(posedge ref_clk) disable iff (!rst_n)
		reti_cmd && !irq_taken |=> gate_reg && stack_read && stack_pointer_reg == stack_addr;
	endproperty
	a_reti_opens: assert property (p_reti_opens) else $error("return did not pop or open gate");
	property p_set_wins;
		@(posedge ref_clk) disable iff (!rst_n)
		(event_set[WIC_BIT_PB]) |=> request_reg[WIC_BIT_PB];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("pin B event lost");
	property p_save_gating;
		@(posedge ref_clk) disable iff (!rst_n)
		pwr_reg == WIC_PWR_SAVE |-> !system_clock_run && oscillators_run && !program_memory_on;
	endproperty
	a_save_gating: assert property (p_save_gating) else $error("power-save gating wrong");
	property p_down_entry;
		@(posedge ref_clk) disable iff (!rst_n)
		pwr_reg == WIC_PWR_ON && sleep_down_cmd |=> !oscillators_run && !program_memory_on;
	endproperty
	a_down_entry: assert property (p_down_entry) else $error("power-down not entered");
	property p_down_no_timer;
		@(posedge ref_clk) disable iff (!rst_n)
		pwr_reg == WIC_PWR_DOWN && !pin_wake |=> pwr_reg == WIC_PWR_DOWN && timer_run == 3'h0;
	endproperty
	a_down_no_timer: assert property (p_down_no_timer) else $error("left power-down without pin");
	property p_cmp_wake;
		@(posedge ref_clk) disable iff (!rst_n)
		pwr_reg == WIC_PWR_SAVE && !pin_wake && !timer_wake && !pin_cfg_reg[WIC_BIT_CMP_WAKE]
			|=> pwr_reg == WIC_PWR_SAVE;
	endproperty
	a_cmp_wake: assert property (p_cmp_wake) else $error("woke without an enabled source");
	property p_fast_wake;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(wake_resume) && $past(pwr_reg) == WIC_PWR_WAKE && wake_ctrl_reg[WIC_BIT_FAST_WAKE]
			|-> $past(wake_cnt_reg) == WIC_WAKE_FAST - 12'h001;
	endproperty
	a_fast_wake: assert property (p_fast_wake) else $error("fast wake count wrong");
endmodule : wic_controller
`default_nettype wire

//--- test/wic_partner.sv
// Far-side model: the low-speed RC oscillator and the CPU's interrupt acknowledge.
// Assumes ref_clk and rst_n come from the bench; the RC period is well above the ref_clk period.
`default_nettype none
module wic_partner #(
	parameter int RC_HALF = 80
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic oscillators_run,
	input  wire logic cpu_irq,
	input  wire logic reti_cmd,
	output var  logic low_speed_rc_osc,
	output var  logic irq_taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic in_service;
	// RC runs in power-save and stops with every oscillator in power-down
	initial begin
		low_speed_rc_osc = 1'b0;
		forever begin
			#(RC_HALF);
			low_speed_rc_osc = oscillators_run ? ~low_speed_rc_osc : 1'b0;
		end
	end
	// One interrupt at a time: a new entry waits for the return
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_taken  <= 1'b0;
			in_service <= 1'b0;
		end else begin
			irq_taken  <= cpu_irq && !in_service && !irq_taken;
			in_service <= (in_service || irq_taken) && !reti_cmd;
		end
	end
endmodule : wic_partner
`default_nettype wire

//--- test/testbench.sv
// Directed bench for the wake-up and interrupt controller over AHB-Lite.
// Assumes wic_partner supplies the RC clock and acknowledges interrupts.
`default_nettype none
`define CHK(n, e, a) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		n_errors++; \
		$display("BAD %s exp %h got %h", n, e, a); \
	end \
end
`define SEE(n, e, a) begin @(negedge ref_clk); `CHK(n, e, a) @(posedge ref_clk); end
`define WAITHI(s) begin k = 0; do begin @(negedge ref_clk); k++; end while ((s) !== 1'b1 && k < 30000); \
	`CHK("wait", 1'b1, s) end
module testbench
	import wic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, comparator_out, irq_taken, low_speed_rc_osc;
	logic        cpu_irq, system_clock_run, oscillators_run, program_memory_on, resume_low_speed, wake_resume;
	logic        stack_write, stack_read;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, timer_match, timer_event, timer_run, pins;
	logic [4:0]  cmd;
	logic [7:0]  stack_addr, rd;
	logic [15:0] vector_addr;
	int          n_errors, check_count, ticks, t0, k, ex;
	// Clock at 50 MHz
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge low_speed_rc_osc) ticks++;
	wic_controller i_wic_controller (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sleep_save_cmd(cmd[0]), .sleep_down_cmd(cmd[1]), .gint_enable_cmd(cmd[2]), .gint_disable_cmd(cmd[3]),
		.irq_taken(irq_taken), .reti_cmd(cmd[4]), .port_a_pin_zero(pins[0]), .port_a_pin_five(pins[1]),
		.port_b_pin_zero(pins[2]), .low_speed_rc_osc(low_speed_rc_osc), .timer_match(timer_match),
		.timer_event(timer_event), .comparator_out(comparator_out), .cpu_irq(cpu_irq),
		.system_clock_run(system_clock_run), .oscillators_run(oscillators_run),
		.program_memory_on(program_memory_on), .resume_low_speed(resume_low_speed), .wake_resume(wake_resume),
		.timer_run(timer_run), .stack_write(stack_write), .stack_read(stack_read), .stack_addr(stack_addr),
		.vector_addr(vector_addr));
	wic_partner i_wic_partner (.ref_clk(ref_clk), .rst_n(rst_n), .oscillators_run(oscillators_run),
		.cpu_irq(cpu_irq), .reti_cmd(cmd[4]), .low_speed_rc_osc(low_speed_rc_osc), .irq_taken(irq_taken));
	// Single word transfer; hready is looked at mid-cycle so the edge decision is race free
	// Select stays up between transfers; IDLE htrans keeps the slave quiet
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		logic r;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do begin
			@(negedge ref_clk) r = hreadyout;
			@(posedge ref_clk);
		end while (!r);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do begin
			@(negedge ref_clk) r = hreadyout;
			rd = hrdata[7:0];
			@(posedge ref_clk);
		end while (!r);
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask : wr
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string n);
		bus(idx, 1'b0, 8'h00);
		`CHK(n, e, rd)
		`CHK("hresp", 1'b0, hresp)
	endtask : rchk
	// One-cycle CPU command strobe
	task automatic pulse(input int b);
		cmd[b] <= 1'b1;
		@(posedge ref_clk);
		cmd[b] <= 1'b0;
	endtask : pulse
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : step
	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// Main sequence
	initial begin
		{rst_n, hsel, hwrite, comparator_out, htrans, timer_match, timer_event, pins, cmd} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		{n_errors, check_count} = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rchk(WIC_IDX_ENABLE, WIC_RST_ZERO, "enable");
		rchk(WIC_IDX_TIMER_CFG, WIC_RST_TIMER_CFG, "timer_cfg");
		rchk(WIC_IDX_STATUS, 8'h00, "status");
		rchk(8'h3f, 8'h00, "unmapped");
		`SEE("vector", WIC_VECTOR, vector_addr)
		wr(WIC_IDX_ENABLE, 8'hff);
		rchk(WIC_IDX_ENABLE, WIC_IRQ_MASK, "enable_bits");
		done("registers");
		// Timer and comparator sources set their flags while their enable bits are clear
		wr(WIC_IDX_ENABLE, 8'h00);
		wr(WIC_IDX_REQUEST, 8'h00);
		wr(WIC_IDX_EDGE, 8'h00);
		timer_event <= 3'h7;
		comparator_out <= 1'b1;
		step(4);
		rchk(WIC_IDX_REQUEST, 8'hd4, "req_all");
		wr(WIC_IDX_REQUEST, 8'h3f);
		rchk(WIC_IDX_REQUEST, 8'h14, "req_part");
		wr(WIC_IDX_EDGE, 8'h10);
		wr(WIC_IDX_REQUEST, 8'h00);
		timer_event <= 3'h0;
		comparator_out <= 1'b0;
		step(4);
		rchk(WIC_IDX_REQUEST, 8'h04, "req_fall");
		// Pin edge codes: rising then falling edge on the shared port-A line
		wr(WIC_IDX_PIN_CFG, 8'h08);
		for (int c = 0; c < 4; c++) begin
			wr(WIC_IDX_EDGE, 8'(c));
			wr(WIC_IDX_REQUEST, 8'h00);
			pins <= 3'h1;
			step(4);
			rchk(WIC_IDX_REQUEST, {7'h0, c < 2}, "rise");
			wr(WIC_IDX_REQUEST, 8'h00);
			pins <= 3'h0;
			step(4);
			rchk(WIC_IDX_REQUEST, {7'h0, c == 0 || c == 2}, "fall");
		end
		wr(WIC_IDX_EDGE, 8'h00);
		wr(WIC_IDX_PIN_CFG, 8'h30);
		wr(WIC_IDX_REQUEST, 8'h00);
		pins <= 3'h6;
		step(4);
		rchk(WIC_IDX_REQUEST, 8'h03, "pin_lines");
		done("requests");
		// Gate, entry and return; the stack pointer stays even
		wr(WIC_IDX_STACK, 8'h20);
		wr(WIC_IDX_ENABLE, 8'h04);
		wr(WIC_IDX_REQUEST, 8'h00);
		timer_event <= 3'h1;
		step(4);
		`SEE("irq_gated", 1'b0, cpu_irq)
		pulse(2);
		`WAITHI(stack_write)
		`CHK("push_addr", 8'h20, stack_addr)
		`CHK("vector", WIC_VECTOR, vector_addr)
		@(posedge ref_clk);
		rchk(WIC_IDX_STACK, 8'h22, "sp_push");
		rchk(WIC_IDX_STATUS, 8'h00, "gate_shut");
		wr(WIC_IDX_REQUEST, 8'h00);
		pulse(4);
		`WAITHI(stack_read)
		`CHK("pop_addr", 8'h20, stack_addr)
		@(posedge ref_clk);
		rchk(WIC_IDX_STACK, 8'h20, "sp_pop");
		rchk(WIC_IDX_STATUS, 8'h04, "gate_open");
		pulse(3);
		rchk(WIC_IDX_STATUS, 8'h00, "gate_off");
		done("interrupt");
		// Power-save: timer 0 on its own running oscillator, timer 1 system-clocked, timer 2 oscillator off
		timer_event <= 3'h0;
		wr(WIC_IDX_TIMER_CFG, 8'h5a);
		wr(WIC_IDX_PIN_CFG, 8'h80);
		pulse(0);
		`SEE("save", 6'h11, {system_clock_run, oscillators_run, program_memory_on, timer_run})
		comparator_out <= 1'b1;
		timer_match <= 3'h2;
		step(6);
		`SEE("no_wake", 1'b0, system_clock_run)
		comparator_out <= 1'b0;
		timer_match <= 3'h1;
		`WAITHI(wake_resume)
		`CHK("resume_rc", 1'b1, resume_low_speed)
		@(posedge ref_clk);
		timer_match <= 3'h0;
		wr(WIC_IDX_PIN_CFG, 8'hc0);
		pulse(0);
		`SEE("asleep", 1'b0, system_clock_run)
		comparator_out <= 1'b1;
		`WAITHI(wake_resume)
		@(posedge ref_clk);
		done("save");
		// Power-down: only input pins with input enabled wake, after the RC delay
		comparator_out <= 1'b0;
		wr(WIC_IDX_PIN_CFG, 8'h19);
		for (int f = 1; f >= 0; f--) begin
			ex = f ? int'(WIC_WAKE_FAST) : int'(WIC_WAKE_NORMAL);
			wr(WIC_IDX_WAKE_CTRL, f ? 8'h20 : 8'h00);
			pulse(1);
			`SEE("down", 4'h0, {system_clock_run, oscillators_run, program_memory_on, timer_run[0]})
			wr(WIC_IDX_ENABLE, 8'hff);
			pins <= pins ^ 3'h5;
			timer_match <= 3'h1;
			step(20);
			`SEE("still_down", 1'b0, oscillators_run)
			timer_match <= 3'h0;
			t0 = ticks;
			pins <= pins ^ 3'h2;
			`WAITHI(wake_resume)
			`CHK("ticks", 1'b1, (ticks - t0 >= ex - 1) && (ticks - t0 <= ex + 2))
			@(posedge ref_clk);
			rchk(WIC_IDX_ENABLE, 8'h04, "kept");
		end
		done("down");
		end_sim();
	end
	// Cuts a hang short; the tests need well under this span
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_errors++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
